// ---- pkg/prc_pkg.sv ----
/*
 * prc_pkg: command codes, field layouts, reset values, sequencer states and the
 * command carrier for the rail configuration bank.
 * assumes one 100 MHz core clock and a command port driven by the bus front end.
 */
// Notes on behaviour
// - pin, conduction, timing writes apply after store+reset
// - pin bit0: 0 soft-start input, 1 good output
// - soft-start mode: ignore ramp rate, enable 5uA source
// - good-output mode drives the rail's good status
// - four paged copies; sequencing policy unpaged
// - policy 0 waits previous good; 1 skips check
// - first start position never waits on good
// - order: stop bits 3:2, start bits 1:0
// - equal positions switch in the same step
// - conduction bit0: 1 continuous, 0 mixed
// - share flag bit1 read-only, master pages only
// - pairs 0/1, 2/3; sharing slave invalid, follows master
// - sharing slave runs 180 degrees from master
// - divisor bits 1:0 give divide 1,2,4,8
// - phase bits 6:2 delay in quarter-oscillator steps
package prc_pkg;
	// ==========================================
	// command codes
	localparam logic [7:0] CMD_PIN_FUNC = 8'hd3;
	localparam logic [7:0] CMD_SEQ_POLICY = 8'hd4;
	localparam logic [7:0] CMD_RAIL_ORDER = 8'hd5;
	localparam logic [7:0] CMD_CONDUCTION = 8'hd6;
	localparam logic [7:0] CMD_SWITCH_TIMING = 8'hd7;
	// ==========================================
	// field positions and widths
	localparam int PIN_SEL_BIT = 0;
	localparam int POLICY_BIT = 0;
	localparam int START_LSB = 0;
	localparam int STOP_LSB = 2;
	localparam int COND_CCM_BIT = 0;
	localparam int COND_SHARE_BIT = 1;
	localparam int DIV_LSB = 0;
	localparam int PHASE_LSB = 2;
	localparam int PHASE_W = 5;
	localparam int NUM_RAILS = 4;
	localparam logic [7:0] LAST_PAGE = 8'h03;
	// ==========================================
	// reset values
	localparam logic [7:0] PIN_RST = 8'h00;
	localparam logic [7:0] POLICY_RST = 8'h00;
	localparam logic [7:0] ORDER_RST = 8'h00;
	localparam logic [7:0] COND_RST = 8'h01;
	localparam logic [3:0][7:0] TIMING_RST = {8'h0c, 8'h04, 8'h08, 8'h00};
	// ==========================================
	// timing: fine phase step in core clocks, and half a period at divide 1
	localparam int FINE_DIV_DEF = 4;
	localparam logic [5:0] HALF_PERIOD_STEPS = 6'h02;

	// sequencer states, gray along idle-start-run-stop
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_START = 2'b01,
		SEQ_RUN = 2'b11,
		SEQ_STOP = 2'b10
	} prc_seq_t;

	// one command request from the bus front end
	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] code;
		logic [7:0] page;
		logic [7:0] data;
	} prc_cmd_t;
endpackage

// ---- hdl/prc_phase_timer.sv ----
/*
 * prc_phase_timer: one rail's switching period counter in fine phase steps.
 * assumes fineTick is a one-cycle enable at four times the oscillator rate.
 */
`timescale 1ns/1ps
module prc_phase_timer (
	input wire logic mclk,
	input wire logic srst,
	input wire logic fineTick,
	input wire logic [1:0] clkDiv,
	input wire logic [4:0] phase,
	output logic pwmStart
);
	import prc_pkg::*;
	// ==========================================
	// period counter
	logic [4:0] cnt_q; // fine steps inside one switching period
	logic [4:0] wrapAt; // last step of the period
	logic hit;

	// period is 4 << div fine steps, so divide 1,2,4,8 of the oscillator
	assign wrapAt = 5'((6'h04 << clkDiv) - 6'h01);
	// a phase past the period folds back into it
	assign hit = fineTick && (cnt_q == (phase & wrapAt));

	// count fine steps, wrap at the period end
	always_ff @(posedge mclk) begin
		if (srst) begin
			cnt_q <= 5'h00;
		end else if (fineTick) begin
			cnt_q <= (cnt_q >= wrapAt) ? 5'h00 : cnt_q + 5'h01;
		end
	end

	// registered start pulse so the output is glitch free
	always_ff @(posedge mclk) begin
		if (srst) begin
			pwmStart <= 1'b0;
		end else begin
			pwmStart <= hit;
		end
	end
endmodule // prc_phase_timer

// ---- hdl/prc_rail_config_regs.sv ----
/*
 * prc_rail_config_regs: paged rail configuration commands, nonvolatile image,
 * rail start/stop sequencer, pin function and per-rail phase timers.
 * assumes a front end that decodes bus transactions into cmdReq pulses and
 * an analog side that acts on the per-rail pin and mode outputs.
 */
`timescale 1ns/1ps
module prc_rail_config_regs #(
	parameter int FINE_DIV = prc_pkg::FINE_DIV_DEF
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic porRst,
	input wire prc_pkg::prc_cmd_t cmdReq,
	input wire logic nvStore,
	output logic [7:0] rdData,
	output logic rdValid,
	output logic cmdInvalid,
	input wire logic [1:0] shareDetect,
	input wire logic [3:0] powerGoodFlag,
	input wire logic seqStart,
	input wire logic seqStop,
	output logic [3:0] railEnable,
	output logic seqBusy,
	input wire logic [3:0] goodflagPinIn,
	output logic [3:0] goodflagPinOut,
	output logic [3:0] goodflagPinOe,
	output logic [3:0] softstartSourceEn,
	output logic [3:0] internalRampIgnore,
	output logic [3:0] continuousMode,
	output logic [3:0] pwmStart
);
	import prc_pkg::*;
	// ==========================================
	// storage
	logic [3:0] nvPin_q, nvCond_q; // nonvolatile image
	logic [3:0][6:0] nvTim_q;
	logic [3:0] wrPin_q, wrCond_q; // host-visible working copies
	logic [3:0][6:0] wrTim_q;
	logic [3:0] livePin_q, liveCond_q; // values steering hardware
	logic [3:0][6:0] liveTim_q;
	logic [3:0][3:0] order_q; // live ordering
	logic policy_q; // 1 skips good check
	prc_seq_t state_q;
	logic [2:0] step_q;
	logic [$clog2(FINE_DIV+1)-1:0] fineCnt_q;
	logic fineTick;

	// ==========================================
	// page decode
	logic [1:0] pg;
	logic paged, pageOk, isMaster, slaveShared, codeOk;
	assign pg = cmdReq.page[1:0];
	assign paged = cmdReq.code != CMD_SEQ_POLICY;
	assign isMaster = !pg[0];
	// sharing slave page refuses access
	assign slaveShared = pg[0] && shareDetect[pg[1]];
	assign pageOk = (cmdReq.page <= LAST_PAGE) && !slaveShared;
	assign codeOk = (cmdReq.code >= CMD_PIN_FUNC) && (cmdReq.code <= CMD_SWITCH_TIMING);
	logic accOk, wrOk;
	assign accOk = codeOk && (!paged || pageOk);
	assign wrOk = cmdReq.write && accOk;

	// ==========================================
	// nonvolatile image: only power-on resets it, store copies working values
	always_ff @(posedge mclk) begin
		if (porRst) begin
			nvPin_q <= {4{PIN_RST[PIN_SEL_BIT]}};
			nvCond_q <= {4{COND_RST[COND_CCM_BIT]}};
			for (int r = 0; r < NUM_RAILS; r++) begin
				nvTim_q[r] <= TIMING_RST[r][6:0];
			end
		end else if (nvStore) begin
			nvPin_q <= wrPin_q;
			nvCond_q <= wrCond_q;
			nvTim_q <= wrTim_q;
		end
	end

	// live copies load only at reset, so host writes never disturb running rails
	always_ff @(posedge mclk) begin
		if (srst || porRst) begin
			livePin_q <= porRst ? {4{PIN_RST[PIN_SEL_BIT]}} : nvPin_q;
			liveCond_q <= porRst ? {4{COND_RST[COND_CCM_BIT]}} : nvCond_q;
			for (int r = 0; r < NUM_RAILS; r++) begin
				liveTim_q[r] <= porRst ? TIMING_RST[r][6:0] : nvTim_q[r];
			end
		end
	end

	// working copies: reloaded at reset, written by host, unused bits dropped
	always_ff @(posedge mclk) begin
		if (porRst) begin
			wrPin_q <= {4{PIN_RST[PIN_SEL_BIT]}};
			wrCond_q <= {4{COND_RST[COND_CCM_BIT]}};
			for (int r = 0; r < NUM_RAILS; r++) begin
				wrTim_q[r] <= TIMING_RST[r][6:0];
			end
		end else if (srst) begin
			wrPin_q <= nvPin_q;
			wrCond_q <= nvCond_q;
			wrTim_q <= nvTim_q;
		end else if (wrOk) begin
			case (cmdReq.code)
				CMD_PIN_FUNC: begin
					wrPin_q[pg] <= cmdReq.data[PIN_SEL_BIT];
				end
				CMD_CONDUCTION: begin
					wrCond_q[pg] <= cmdReq.data[COND_CCM_BIT]; // share bit is read-only
				end
				CMD_SWITCH_TIMING: begin
					wrTim_q[pg] <= cmdReq.data[6:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ordering and policy act at once; host keeps them still mid-sequence
	always_ff @(posedge mclk) begin
		if (srst || porRst) begin
			policy_q <= POLICY_RST[POLICY_BIT];
			for (int r = 0; r < NUM_RAILS; r++) begin
				order_q[r] <= ORDER_RST[3:0];
			end
		end else if (wrOk && cmdReq.code == CMD_SEQ_POLICY) begin
			policy_q <= cmdReq.data[POLICY_BIT]; // single unpaged copy
		end else if (wrOk && cmdReq.code == CMD_RAIL_ORDER) begin
			order_q[pg] <= cmdReq.data[3:0];
		end
	end

	// ==========================================
	// read path and refusal
	always_ff @(posedge mclk) begin
		if (srst || porRst) begin
			rdData <= 8'h00;
			rdValid <= 1'b0;
			cmdInvalid <= 1'b0;
		end else begin
			rdValid <= cmdReq.read && accOk;
			cmdInvalid <= (cmdReq.read || cmdReq.write) && !accOk;
			if (cmdReq.read) begin
				rdData <= 8'h00; // unused bits and refused reads give zero
				if (accOk) begin
					case (cmdReq.code)
						CMD_PIN_FUNC: begin
							rdData <= {7'h00, wrPin_q[pg]};
						end
						CMD_SEQ_POLICY: begin
							rdData <= {7'h00, policy_q};
						end
						CMD_RAIL_ORDER: begin
							rdData <= {4'h0, order_q[pg]};
						end
						CMD_CONDUCTION: begin
							// share flag only seen from the master page
							rdData <= {6'h00, isMaster && shareDetect[pg[1]], wrCond_q[pg]};
						end
						CMD_SWITCH_TIMING: begin
							rdData <= {1'b0, wrTim_q[pg]};
						end
						default: begin
							rdData <= 8'h00;
						end
					endcase
				end
			end
		end
	end

	// ==========================================
	// effective per-rail settings: a sharing slave copies its master, with its phase moved by half a period
	logic [3:0] effPin, effCond;
	logic [3:0][3:0] effOrder;
	logic [3:0][6:0] effTim;
	always_comb begin
		for (int r = 0; r < NUM_RAILS; r++) begin
			effPin[r] = livePin_q[r];
			effCond[r] = liveCond_q[r];
			effOrder[r] = order_q[r];
			effTim[r] = liveTim_q[r];
			if (r[0] && shareDetect[r / 2]) begin
				effPin[r] = livePin_q[r - 1];
				effCond[r] = liveCond_q[r - 1];
				effOrder[r] = order_q[r - 1];
				effTim[r][1:0] = liveTim_q[r - 1][1:0];
				// half period is 2 << div fine steps, wrapped to the period
				effTim[r][6:2] = 5'((6'(liveTim_q[r - 1][6:2]) + (HALF_PERIOD_STEPS << liveTim_q[r - 1][1:0]))
					& ((6'h04 << liveTim_q[r - 1][1:0]) - 6'h01));
			end
		end
	end

	// ==========================================
	// pin function and conduction outputs
	always_comb begin
		for (int r = 0; r < NUM_RAILS; r++) begin
			goodflagPinOe[r] = effPin[r];
			goodflagPinOut[r] = powerGoodFlag[r];
			softstartSourceEn[r] = !effPin[r]; // 5uA source on
			internalRampIgnore[r] = !effPin[r];
			continuousMode[r] = effCond[r];
		end
	end

	// ==========================================
	// sequencer
	logic stepGood; // every rail placed before this step is good
	logic [3:0] startHere, stopHere;
	always_comb begin
		stepGood = 1'b1;
		for (int r = 0; r < NUM_RAILS; r++) begin
			startHere[r] = {1'b0, effOrder[r][START_LSB +: 2]} == step_q;
			stopHere[r] = {1'b0, effOrder[r][STOP_LSB +: 2]} == step_q;
			if ({1'b0, effOrder[r][START_LSB +: 2]} < step_q && !goodflagPinIn[r] && !powerGoodFlag[r]) begin
				stepGood = 1'b0;
			end
		end
	end
	logic startGo;
	// first position has no predecessor; policy 1 skips the check
	assign startGo = (step_q == 3'h0) || policy_q || stepGood;

	// one position per step; start steps wait, stop steps take one cycle each
	always_ff @(posedge mclk) begin
		if (srst || porRst) begin
			state_q <= SEQ_IDLE;
			step_q <= 3'h0;
			railEnable <= 4'h0;
		end else begin
			case (state_q)
				SEQ_IDLE: begin
					step_q <= 3'h0;
					if (seqStart) begin
						state_q <= SEQ_START;
					end else if (seqStop) begin
						state_q <= SEQ_STOP;
					end
				end
				SEQ_START: begin
					if (seqStop) begin
						// abort an unfinished start into a stop
						state_q <= SEQ_STOP;
						step_q <= 3'h0;
					end else if (startGo) begin
						railEnable <= railEnable | startHere;
						step_q <= step_q + 3'h1;
						if (step_q == 3'h3) begin
							state_q <= SEQ_RUN;
						end
					end
				end
				SEQ_RUN: begin
					step_q <= 3'h0;
					if (seqStop) begin
						state_q <= SEQ_STOP;
					end
				end
				SEQ_STOP: begin
					railEnable <= railEnable & ~stopHere;
					step_q <= step_q + 3'h1;
					if (step_q == 3'h3) begin
						state_q <= SEQ_IDLE;
					end
				end
				default: begin
					state_q <= SEQ_IDLE;
				end
			endcase
		end
	end
	assign seqBusy = (state_q == SEQ_START) || (state_q == SEQ_STOP);

	// ==========================================
	// fine phase step enable, a quarter oscillator period
	always_ff @(posedge mclk) begin
		if (srst || porRst) begin
			fineCnt_q <= '0;
		end else begin
			fineCnt_q <= fineTick ? '0 : fineCnt_q + ($clog2(FINE_DIV+1))'(1);
		end
	end
	assign fineTick = fineCnt_q == ($clog2(FINE_DIV+1))'(FINE_DIV - 1);

	// one period timer per rail
	for (genvar g = 0; g < NUM_RAILS; g++) begin : gRail
		prc_phase_timer uTimer (
			.mclk(mclk),
			.srst(srst || porRst),
			.fineTick(fineTick),
			.clkDiv(effTim[g][DIV_LSB +: 2]),
			.phase(effTim[g][PHASE_LSB - 2 + 2 +: PHASE_W - 0] >> 0),
			.pwmStart(pwmStart[g])
		);
	end
endmodule // prc_rail_config_regs

// ---- test/prc_props.sv ----
/* prc_props: port-level checks of the rail configuration bank.
   assumes one clock mclk and resets srst/porRst, both sync high. */
`timescale 1ns/1ps
module prc_props (
	input wire logic mclk,
	input wire logic srst,
	input wire logic porRst,
	input wire prc_pkg::prc_cmd_t cmdReq,
	input wire logic [7:0] rdData,
	input wire logic rdValid,
	input wire logic cmdInvalid,
	input wire logic [1:0] shareDetect,
	input wire logic [3:0] powerGoodFlag,
	input wire logic seqStart,
	input wire logic seqStop,
	input wire logic [3:0] railEnable,
	input wire logic seqBusy,
	input wire logic [3:0] goodflagPinOut,
	input wire logic [3:0] goodflagPinOe,
	input wire logic [3:0] softstartSourceEn,
	input wire logic [3:0] internalRampIgnore,
	input wire logic [3:0] continuousMode
);
	import prc_pkg::*;
	// ==========================================
	// decode helpers
	wire logic req = cmdReq.write | cmdReq.read; // any request
	wire logic okCode = cmdReq.code >= CMD_PIN_FUNC && cmdReq.code <= CMD_SWITCH_TIMING; // known code
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst || porRst);
	// ==========================================
	// assertions
	good_pin_a: assert property (goodflagPinOut == powerGoodFlag) else $error("good pin wrong");
	src_mode_a: assert property (softstartSourceEn == ~goodflagPinOe) else $error("source mode wrong");
	ramp_ign_a: assert property (internalRampIgnore == ~goodflagPinOe) else $error("ramp ignore wrong");
	read_once_a: assert property (cmdReq.read && !cmdReq.write |=> rdValid ^ cmdInvalid)
		else $error("read answer wrong");
	bad_code_a: assert property (req && !okCode |=> cmdInvalid && !rdValid) else $error("bad code kept");
	bad_page_a: assert property (req && okCode && cmdReq.code != CMD_SEQ_POLICY && cmdReq.page > 8'h03
		|=> cmdInvalid) else $error("bad page kept");
	write_ok_a: assert property (cmdReq.write && okCode && cmdReq.page <= 8'h03 && !cmdReq.page[0]
		|=> !cmdInvalid && !rdValid) else $error("good write refused");
	// a change of sharing may legally move a slave's copied settings, host writes may not
	live_hold_a: assert property (!srst && !porRst |=> ($stable(shareDetect) |-> $stable(goodflagPinOe)
		&& $stable(continuousMode))) else $error("live config moved");
	share_flag_a: assert property (cmdReq.read && cmdReq.code == CMD_CONDUCTION && cmdReq.page == 8'h00
		&& shareDetect[0] |=> rdValid && rdData[1]) else $error("share flag low");
	stop_all_a: assert property (seqStop |-> ##[1:8] railEnable == 4'h0) else $error("stop incomplete");
	// ==========================================
	// covers
	rd_c: cover property (rdValid);
	inv_c: cover property (cmdInvalid);
	all_on_c: cover property (railEnable == 4'hf);
endmodule // prc_props

bind prc_rail_config_regs prc_props u_prc_props (.mclk, .srst, .porRst, .cmdReq, .rdData, .rdValid, .cmdInvalid,
	.shareDetect, .powerGoodFlag, .seqStart, .seqStop, .railEnable, .seqBusy, .goodflagPinOut, .goodflagPinOe,
	.softstartSourceEn, .internalRampIgnore, .continuousMode);

// ---- test/prc_host_model.sv ----
/* prc_host_model: bus host issuing one command per call.
   assumes requests launch on the falling edge of mclk. */
`timescale 1ns/1ps
module prc_host_model (
	input wire logic mclk,
	output prc_pkg::prc_cmd_t cmdReq,
	input wire logic [7:0] rdData,
	input wire logic rdValid,
	input wire logic cmdInvalid
);
	import prc_pkg::*;
	// ==========================================
	// idle bus shows inverted leftovers, not a kind repeat of the last value
	initial cmdReq = '0;
	// caller keeps order/policy writes out of running sequences
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] page, input logic [7:0] data,
		output logic [7:0] rd, output logic val, output logic inv);
		@(negedge mclk);
		cmdReq = '{wr, ~wr, code, page, data};
		@(negedge mclk);
		rd = rdData;
		val = rdValid;
		inv = cmdInvalid;
		cmdReq = '{1'b0, 1'b0, ~code, ~page, ~data};
	endtask
endmodule // prc_host_model

// ---- test/tb.sv ----
/* tb: command-level test of the rail configuration bank.
   assumes the bound checker and the host model beside it. */
`timescale 1ns/1ps
module tb;
	import prc_pkg::*;
	logic mclk = 0, srst = 1, porRst = 1, nvStore = 0, seqStart = 0, seqStop = 0;
	logic [1:0] shareDetect = 2'h0;
	logic [3:0] powerGoodFlag = 4'h0;
	logic [3:0] goodflagPinIn = 4'h0; // pin level seen back, counts as good for sequencing
	logic [3:0] railEnable, goodflagPinOut, goodflagPinOe, softstartSourceEn, internalRampIgnore, continuousMode;
	logic [3:0] pwmStart; // period start pulses, one per rail
	logic [7:0] rdData;
	logic rdValid, cmdInvalid, seqBusy;
	prc_cmd_t cmdReq;
	logic [4:0] phs [4] = '{5'h00, 5'h02, 5'h01, 5'h03}; // default phase per page
	int mismatches = 0;
	int n_checks = 0;
	always #5 mclk = ~mclk;
	prc_rail_config_regs #(.FINE_DIV(1)) u_prc_rail_config_regs (.mclk, .srst, .porRst, .cmdReq, .nvStore, .rdData,
		.rdValid, .cmdInvalid, .shareDetect, .powerGoodFlag, .seqStart, .seqStop, .railEnable, .seqBusy,
		.goodflagPinIn, .goodflagPinOut, .goodflagPinOe, .softstartSourceEn, .internalRampIgnore,
		.continuousMode, .pwmStart);
	prc_host_model u_host (.mclk, .cmdReq, .rdData, .rdValid, .cmdInvalid);
	// ==========================================
	// compare and access tasks
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic acc(input logic wr, input logic [7:0] code, input logic [7:0] page, input logic [7:0] data,
		input logic [7:0] exp, input logic inv);
		logic [7:0] r;
		logic v;
		logic i;
		u_host.xfer(wr, code, page, data, r, v, i);
		chk("refused", {7'h0, inv}, {7'h0, i});
		if (!wr) begin
			chk("read valid", {7'h0, !inv}, {7'h0, v});
			chk("read data", exp, r);
		end
	endtask
	task automatic kick(input logic stop);
		@(negedge mclk);
		if (stop) seqStop = 1;
		else seqStart = 1;
		@(negedge mclk);
		seqStop = 0;
		seqStart = 0;
	endtask
	// bounded wait; running out counts as a mismatch and ends the run
	task automatic wait_en(input logic [3:0] exp);
		for (int k = 0; k < 20; k++) begin
			@(negedge mclk);
			if (railEnable === exp) begin
				n_checks++;
				return;
			end
		end
		chk("rail enables", {4'h0, exp}, {4'h0, railEnable});
		wrap_up();
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// store working config to the nonvolatile image, then reload it by a soft reset
	task automatic store_reload();
		@(negedge mclk) nvStore = 1;
		@(negedge mclk) nvStore = 0;
		srst = 1;
		@(negedge mclk) srst = 0;
	endtask
	// cycles from a rail 0 period start to the next period start of rail r; bounded
	task automatic pwm_gap(input int r, input logic [7:0] exp);
		int k;
		int g;
		for (k = 0; k < 40 && pwmStart[0] !== 1'b1; k++) begin
			@(negedge mclk);
		end
		for (g = 1; g < 40; g++) begin
			@(negedge mclk);
			if (pwmStart[r] === 1'b1) begin
				break;
			end
		end
		chk("pwm gap", exp, 8'(g));
		if (k >= 40 || g >= 40) begin
			chk("pwm timeout", 8'h00, 8'h01);
			wrap_up();
		end
	endtask
	// ==========================================
	// main sequence
	initial begin
		repeat (8) @(negedge mclk);
		srst = 0;
		porRst = 0;
		for (int p = 0; p < 4; p++) begin
			acc(0, CMD_PIN_FUNC, 8'(p), 0, 8'h00, 0);
			acc(0, CMD_RAIL_ORDER, 8'(p), 0, 8'h00, 0);
			acc(0, CMD_CONDUCTION, 8'(p), 0, 8'h01, 0);
			acc(0, CMD_SWITCH_TIMING, 8'(p), 0, {1'b0, phs[p], 2'b00}, 0);
		end
		acc(0, CMD_SEQ_POLICY, 8'h00, 0, 8'h00, 0);
		acc(1, CMD_SEQ_POLICY, 8'h07, 8'hff, 0, 0);
		acc(0, CMD_SEQ_POLICY, 8'h00, 0, 8'h01, 0);
		acc(1, CMD_RAIL_ORDER, 8'h04, 0, 0, 1);
		acc(0, 8'hd8, 8'h00, 0, 0, 1);
		acc(1, CMD_PIN_FUNC, 8'h00, 8'hff, 0, 0);
		acc(0, CMD_PIN_FUNC, 8'h00, 0, 8'h01, 0);
		acc(1, CMD_CONDUCTION, 8'h02, 8'hfe, 0, 0);
		acc(0, CMD_CONDUCTION, 8'h02, 0, 8'h00, 0);
		chk("pin oe before store", 8'h00, {4'h0, goodflagPinOe});
		store_reload();
		chk("pin oe", 8'h01, {4'h0, goodflagPinOe});
		chk("source en", 8'h0e, {4'h0, softstartSourceEn});
		chk("ramp ignore", 8'h0e, {4'h0, internalRampIgnore});
		chk("conduction", 8'h0b, {4'h0, continuousMode});
		pwm_gap(2, 8'h01);
		pwm_gap(0, 8'h04);
		powerGoodFlag = 4'h5;
		#1 chk("good pin", 8'h05, {4'h0, goodflagPinOut});
		powerGoodFlag = 4'h0;
		acc(0, CMD_SEQ_POLICY, 8'h00, 0, 8'h00, 0);
		acc(1, CMD_RAIL_ORDER, 8'h00, 8'h0c, 0, 0);
		acc(1, CMD_RAIL_ORDER, 8'h01, 8'h01, 0, 0);
		acc(1, CMD_RAIL_ORDER, 8'h02, 8'h01, 0, 0);
		acc(1, CMD_RAIL_ORDER, 8'h03, 8'h03, 0, 0);
		kick(0);
		wait_en(4'h1);
		repeat (6) @(negedge mclk);
		chk("held by good", 8'h01, {4'h0, railEnable});
		goodflagPinIn = 4'h1;
		wait_en(4'h7);
		powerGoodFlag = 4'h7;
		wait_en(4'hf);
		kick(1);
		wait_en(4'h1);
		wait_en(4'h0);
		powerGoodFlag = 4'h0;
		goodflagPinIn = 4'h0;
		acc(1, CMD_SEQ_POLICY, 8'h00, 8'h01, 0, 0);
		kick(0);
		wait_en(4'hf);
		kick(1);
		wait_en(4'h0);
		shareDetect = 2'h1;
		acc(0, CMD_CONDUCTION, 8'h01, 0, 8'h00, 1);
		acc(0, CMD_CONDUCTION, 8'h00, 0, 8'h03, 0);
		acc(1, CMD_SWITCH_TIMING, 8'h00, 8'h85, 0, 0);
		acc(0, CMD_SWITCH_TIMING, 8'h00, 0, 8'h05, 0);
		store_reload();
		pwm_gap(0, 8'h08);
		pwm_gap(1, 8'h04);
		kick(0);
		@(negedge mclk);
		chk("same step", 8'h0f, {4'h0, railEnable});
		kick(1);
		wait_en(4'h0);
		wrap_up();
	end
endmodule // tb
